// ---- common/cch_defines.svh ----
// Purpose: Named constants of the common command handler.
// Assumes: Included by bare name by the package and the design files.
// Notes:   Bit positions refer to the standard event status byte.
`ifndef CCH_DEFINES_SVH
`define CCH_DEFINES_SVH

`define CCH_SESR_W      8
`define CCH_SESR_OPC    0
`define CCH_SESR_QYE    2
`define CCH_SESR_DDE    3
`define CCH_SESR_EXE    4
`define CCH_SESR_CME    5
`define CCH_SESR_PON    7
`define CCH_SESR_USED   8'hBD
`define CCH_SESR_RESET  8'h80
`define CCH_IDX_W       6
`define CCH_PASS_LEN    6'h04
`define CCH_ONE_LEN     6'h01
`define CCH_CHAR_ZERO   8'h30
`define CCH_CHAR_ONE    8'h31

`endif

// ---- common/cch_pkg.sv ----
// Purpose: Types shared by the common command handler files.
// Assumes: Commands arrive already parsed into one code each.
// Notes:   Enumeration codes follow declaration order from zero.
`include "cch_defines.svh"

package cch_pkg;

    typedef enum logic [3:0] {
        CMD_IDN,
        CMD_RST,
        CMD_TST,
        CMD_TRG,
        CMD_OPC,
        CMD_OPCQ,
        CMD_WAI,
        CMD_ESRQ,
        CMD_UNKNOWN
    } cch_cmd_type;

    typedef enum logic [2:0] {
        RSP_IDN,
        RSP_PASS,
        RSP_FAIL,
        RSP_ONE,
        RSP_NUM
    } cch_rsp_type;

endpackage

// ---- core/cch_responder.sv ----
// Purpose: Streams one reply message as ASCII bytes.
// Assumes: A new start comes only while no reply is being sent.
// Notes:   Numbers are sent in decimal without leading zeros.
`timescale 1ns/1ps
`include "cch_defines.svh"

module cch_responder
    import cch_pkg::*;
#(
    parameter int          ID_LEN  = 29,
    // Identification text; the value is arbitrary.
    parameter logic [231:0] ID_TEXT = "VENDOR,SWMAIN,000000001,V1.00"
) (
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   reset,
    // Reply request.
    input  wire logic                   start,
    input  wire cch_rsp_type            kind,
    input  wire logic [`CCH_SESR_W-1:0] value,
    // Byte stream.
    output logic                        resp_valid,
    output logic [7:0]                  resp_byte,
    output logic                        resp_last,
    input  wire logic                   resp_ready
);

    cch_rsp_type            kind_q;
    logic [`CCH_SESR_W-1:0] value_q;
    logic [`CCH_IDX_W-1:0]  idx;
    logic [`CCH_IDX_W-1:0]  next_idx;
    cch_rsp_type            next_kind;
    logic [`CCH_SESR_W-1:0] next_value;
    logic [`CCH_IDX_W-1:0]  next_len;
    logic [7:0]             next_byte;
    logic [3:0]             digit [3];
    logic [1:0]             skip;
    logic [5:0]             id_pos;

    always_comb begin
        next_kind  = start ? kind : kind_q;
        next_value = start ? value : value_q;
        next_idx   = start ? '0 : idx + `CCH_IDX_W'(1);
        digit[0]   = 4'(next_value / 8'h64);
        digit[1]   = 4'((next_value / 8'h0A) % 8'h0A);
        digit[2]   = 4'(next_value % 8'h0A);
        skip       = (next_value >= 8'h64) ? 2'h0 :
                     (next_value >= 8'h0A) ? 2'h1 : 2'h2;
        id_pos     = 6'(ID_LEN - 1) - next_idx;
        next_len   = `CCH_ONE_LEN;
        next_byte  = `CCH_CHAR_ONE;
        case (next_kind)
            RSP_IDN: begin
                next_len  = `CCH_IDX_W'(ID_LEN);
                next_byte = ID_TEXT[8*id_pos +: 8];
            end
            RSP_PASS: begin
                next_len  = `CCH_PASS_LEN;
                next_byte = 8'("PASS" >> (8 * (3 - next_idx[1:0])));
            end
            RSP_FAIL: begin
                next_len  = `CCH_PASS_LEN;
                next_byte = 8'("FAIL" >> (8 * (3 - next_idx[1:0])));
            end
            RSP_NUM: begin
                next_len  = `CCH_IDX_W'(3 - skip);
                next_byte = `CCH_CHAR_ZERO +
                            8'(digit[2'(skip + next_idx[1:0])]);
            end
            default: begin
                next_len  = `CCH_ONE_LEN;
                next_byte = `CCH_CHAR_ONE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            resp_valid <= 1'b0;
            resp_last  <= 1'b0;
            resp_byte  <= '0;
            idx        <= '0;
            kind_q     <= RSP_ONE;
            value_q    <= '0;
        end else if (start || (resp_valid && resp_ready && !resp_last)) begin
            resp_valid <= 1'b1;
            resp_last  <= (next_idx == next_len - `CCH_IDX_W'(1));
            resp_byte  <= next_byte;
            idx        <= next_idx;
            kind_q     <= next_kind;
            value_q    <= next_value;
        end else if (resp_valid && resp_ready) begin
            resp_valid <= 1'b0;
            resp_last  <= 1'b0;
        end
    end

endmodule

// ---- core/cch_top.sv ----
// Purpose: Executes the common commands of a relay switch mainframe.
// Assumes: Commands arrive parsed; op_busy marks an operation in flight.
// Notes:   Communication settings live elsewhere and are never touched.
`timescale 1ns/1ps
`include "cch_defines.svh"

module cch_top
    import cch_pkg::*;
(
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   reset,
    // Parsed commands.
    input  wire logic                   cmd_valid,
    input  wire cch_cmd_type            cmd_code,
    output logic                        cmd_ready,
    // Reply bytes.
    output logic                        resp_valid,
    output logic [7:0]                  resp_byte,
    output logic                        resp_last,
    input  wire logic                   resp_ready,
    // Operation and scan status.
    input  wire logic                   op_busy,
    input  wire logic                   scan_list_enabled,
    input  wire logic                   scan_finished,
    output logic                        scan_active,
    output logic                        scan_start,
    output logic                        scan_advance,
    // Initialisation of the relay side.
    output logic                        settings_reset,
    output logic                        open_all_channels,
    // Self-test engine.
    output logic                        selftest_start,
    input  wire logic                   selftest_done,
    input  wire logic                   selftest_fail,
    // Standard event status view.
    output logic [`CCH_SESR_W-1:0]      sesr
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_TEST, ST_HOLD, ST_RESP
    } cch_state_type;

    cch_state_type          state;
    cch_state_type          next_state;
    cch_cmd_type            hold_kind;
    cch_cmd_type            pend_code;
    cch_cmd_type            cur;
    logic                   pend_valid;
    logic                   next_pend;
    logic                   take;
    logic                   go;
    logic                   wai_trg;
    logic                   do_trg;
    logic                   rsp_start;
    cch_rsp_type            rsp_kind;
    logic [`CCH_SESR_W-1:0] set_bits;
    logic [`CCH_SESR_W-1:0] clr_bits;

    assign take    = cmd_valid && cmd_ready;
    assign cur     = pend_valid ? pend_code : cmd_code;
    assign go      = (state == ST_IDLE) && (pend_valid || take);
    assign wai_trg = (state == ST_HOLD) && (hold_kind == CMD_WAI) && take &&
                     (cmd_code == CMD_TRG);
    assign do_trg  = (go && cur == CMD_TRG) || wai_trg;

    always_comb begin
        next_state = state;
        rsp_start  = 1'b0;
        rsp_kind   = RSP_ONE;
        set_bits   = '0;
        clr_bits   = '0;
        next_pend  = pend_valid;
        case (state)
            ST_IDLE: begin
                next_pend = 1'b0;
                if (go) begin
                    case (cur)
                        CMD_IDN: begin
                            rsp_start  = 1'b1;
                            rsp_kind   = RSP_IDN;
                            next_state = ST_RESP;
                        end
                        CMD_TST: begin
                            if (scan_active) begin
                                set_bits[`CCH_SESR_EXE] = 1'b1;
                            end else begin
                                next_state = ST_TEST;
                            end
                        end
                        CMD_OPC, CMD_OPCQ, CMD_WAI: begin
                            next_state = ST_HOLD;
                        end
                        CMD_ESRQ: begin
                            rsp_start  = 1'b1;
                            rsp_kind   = RSP_NUM;
                            clr_bits   = '1;
                            next_state = ST_RESP;
                        end
                        CMD_UNKNOWN: begin
                            set_bits[`CCH_SESR_CME] = 1'b1;
                        end
                        default: begin
                            next_state = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_TEST: begin
                if (selftest_done) begin
                    rsp_start  = 1'b1;
                    rsp_kind   = selftest_fail ? RSP_FAIL : RSP_PASS;
                    next_state = ST_RESP;
                end
            end
            ST_HOLD: begin
                if (take && !wai_trg) begin
                    next_pend = 1'b1;
                end
                if (!op_busy) begin
                    next_state = ST_IDLE;
                    if (hold_kind == CMD_OPC) begin
                        set_bits[`CCH_SESR_OPC] = 1'b1;
                    end
                    if (hold_kind == CMD_OPCQ) begin
                        rsp_start  = 1'b1;
                        rsp_kind   = RSP_ONE;
                        next_state = ST_RESP;
                    end
                end
            end
            ST_RESP: begin
                if (!resp_valid && !selftest_start) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state     <= ST_IDLE;
            hold_kind <= CMD_WAI;
        end else begin
            state <= next_state;
            if (go) begin
                hold_kind <= cur;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pend_valid <= 1'b0;
            pend_code  <= CMD_UNKNOWN;
            cmd_ready  <= 1'b0;
        end else begin
            pend_valid <= next_pend;
            if (state == ST_HOLD && take && !wai_trg) begin
                pend_code <= cmd_code;
            end
            // Only a wait hold keeps the port open.
            cmd_ready <= !next_pend && ((next_state == ST_IDLE) ||
                         (next_state == ST_HOLD &&
                          (go ? cur : hold_kind) == CMD_WAI));
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            scan_active  <= 1'b0;
            scan_start   <= 1'b0;
            scan_advance <= 1'b0;
        end else begin
            scan_start   <= do_trg && !scan_active && scan_list_enabled;
            scan_advance <= do_trg && scan_active;
            if (go && cur == CMD_RST) begin
                scan_active <= 1'b0;
            end else if (do_trg && scan_list_enabled) begin
                scan_active <= 1'b1;
            end else if (scan_finished) begin
                scan_active <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            settings_reset    <= 1'b0;
            open_all_channels <= 1'b0;
            selftest_start    <= 1'b0;
        end else begin
            settings_reset    <= go && cur == CMD_RST;
            open_all_channels <= go && cur == CMD_RST;
            selftest_start    <= go && cur == CMD_TST && !scan_active;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sesr <= `CCH_SESR_RESET;
        end else begin
            sesr <= ((sesr & ~clr_bits) | set_bits) & `CCH_SESR_USED;
        end
    end

    cch_responder u_responder (
        .clk        (clk),
        .reset      (reset),
        .start      (rsp_start),
        .kind       (rsp_kind),
        .value      (sesr),
        .resp_valid (resp_valid),
        .resp_byte  (resp_byte),
        .resp_last  (resp_last),
        .resp_ready (resp_ready)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    idn_reply_a: assert property (
        go && cur == CMD_IDN |-> ##1 resp_valid && resp_byte == "V")
        else $error("identification reply did not start");
    rst_open_a: assert property (
        go && cur == CMD_RST |=> open_all_channels && !scan_active)
        else $error("reset did not open channels");
    rst_scope_a: assert property (
        go && cur == CMD_RST |=> settings_reset && $stable(sesr))
        else $error("reset disturbed status");
    tst_run_a: assert property (
        state == ST_TEST && selftest_done |-> ##1 resp_valid &&
        resp_byte == ($past(selftest_fail) ? "F" : "P"))
        else $error("self-test reply wrong");
    tst_scan_err_a: assert property (
        go && cur == CMD_TST && scan_active |=> !selftest_start &&
        sesr[`CCH_SESR_EXE])
        else $error("self-test ran during scan");
    trg_start_a: assert property (
        do_trg && !scan_active && scan_list_enabled |=> scan_start &&
        scan_active)
        else $error("trigger did not start scan");
    trg_advance_a: assert property (
        do_trg && scan_active |=> scan_advance)
        else $error("trigger did not advance scan");
    opc_set_a: assert property (
        state == ST_HOLD && hold_kind == CMD_OPC && !op_busy |=>
        sesr[`CCH_SESR_OPC])
        else $error("completion bit not set");
    hold_closed_a: assert property (
        state == ST_HOLD && hold_kind != CMD_WAI |-> !cmd_ready)
        else $error("command taken during completion hold");
    opcq_reply_a: assert property (
        state == ST_HOLD && hold_kind == CMD_OPCQ && !op_busy |->
        ##1 resp_valid && resp_byte == `CCH_CHAR_ONE && resp_last)
        else $error("completion query reply wrong");
    wai_trg_a: assert property (
        wai_trg && scan_active |=> scan_advance &&
        (state == ST_HOLD || !$past(op_busy)))
        else $error("trigger lost during wait");
    wai_quiet_a: assert property (
        state == ST_HOLD && hold_kind == CMD_WAI && !op_busy |=>
        sesr[`CCH_SESR_OPC] == $past(sesr[`CCH_SESR_OPC]))
        else $error("wait changed completion bit");
    unused_zero_a: assert property (
        (sesr & ~`CCH_SESR_USED) == '0)
        else $error("unused status bit set");
    one_at_time_a: assert property (
        state != ST_IDLE && state != ST_HOLD |-> !cmd_ready)
        else $error("command taken while busy");

    scan_walk_c: cover property (scan_start ##[1:50] scan_advance);
    tst_pass_c: cover property (selftest_start ##[1:50] resp_valid);
    wai_trg_c: cover property (wai_trg);
    opcq_c: cover property (state == ST_HOLD && hold_kind == CMD_OPCQ
                            ##1 rsp_start);

endmodule

// ---- verification/cch_host_model.sv ----
// Purpose: Host side model that sinks reply bytes and acts as self-test.
// Assumes: Reply bytes follow a valid and ready handshake.
// Notes:   The fail line carries noise outside the done pulse.
`timescale 1ns/1ps

module cch_host_model (
    // Clock, reset and mode.
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        slow,
    input  wire logic        fail_mode,
    // Reply stream.
    input  wire logic        resp_valid,
    input  wire logic [7:0]  resp_byte,
    input  wire logic        resp_last,
    output logic             resp_ready,
    // Self-test engine.
    input  wire logic        selftest_start,
    output logic             selftest_done,
    output logic             selftest_fail,
    // Collected replies.
    output int               n_replies,
    output int               rx_count,
    output logic [63:0]      rx_tail
);
    logic [2:0] st_cnt;
    logic       noise;

    // Slow mode drops ready on every other clock cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            resp_ready <= 1'b0;
            n_replies  <= 0;
            rx_count   <= 0;
            rx_tail    <= 64'h0;
        end else begin
            resp_ready <= slow ? ~resp_ready : 1'b1;
            if (resp_valid && resp_ready) begin
                rx_tail  <= {rx_tail[55:0], resp_byte};
                rx_count <= rx_count + 1;
                if (resp_last) begin
                    n_replies <= n_replies + 1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_cnt <= 3'h0;
            noise  <= 1'b0;
        end else begin
            noise  <= ~noise;
            st_cnt <= selftest_start ? 3'h4 : (st_cnt != 3'h0 ? st_cnt - 3'h1
                                                             : 3'h0);
        end
    end

    assign selftest_done = (st_cnt == 3'h1);
    assign selftest_fail = selftest_done ? fail_mode : noise;
endmodule

// ---- verification/common_command_handler_tb.sv ----
// Purpose: Self-checking bench of the common command handler.
// Assumes: Default identification text of the responder.
// Notes:   Expected replies and status are kept by the bench itself.
`timescale 1ns/1ps

module common_command_handler_tb;
    import cch_pkg::*;

    logic        clk, reset, cmd_valid, cmd_ready, resp_valid, resp_last;
    logic        resp_ready, op_busy, scan_list_enabled, scan_finished;
    logic        scan_active, scan_start, scan_advance, settings_reset;
    logic        open_all_channels, selftest_start, selftest_done;
    logic        selftest_fail, slow, fail_mode;
    logic [7:0]  resp_byte, sesr, e_sesr;
    logic [63:0] rx_tail;
    cch_cmd_type cmd_code;
    int          fails, n_tests, seed, nb, prev_n, prev_c, n_replies;
    int          rx_count, n_start, n_adv, n_rst, n_open, n_st;

    cch_top uut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .resp_byte(resp_byte), .resp_last(resp_last),
        .resp_ready(resp_ready), .op_busy(op_busy),
        .scan_list_enabled(scan_list_enabled),
        .scan_finished(scan_finished), .scan_active(scan_active),
        .scan_start(scan_start), .scan_advance(scan_advance),
        .settings_reset(settings_reset),
        .open_all_channels(open_all_channels),
        .selftest_start(selftest_start), .selftest_done(selftest_done),
        .selftest_fail(selftest_fail), .sesr(sesr));

    cch_host_model host (.clk(clk), .reset(reset), .slow(slow),
        .fail_mode(fail_mode), .resp_valid(resp_valid),
        .resp_byte(resp_byte), .resp_last(resp_last),
        .resp_ready(resp_ready), .selftest_start(selftest_start),
        .selftest_done(selftest_done), .selftest_fail(selftest_fail),
        .n_replies(n_replies), .rx_count(rx_count), .rx_tail(rx_tail));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (scan_start === 1'b1) n_start++;
        if (scan_advance === 1'b1) n_adv++;
        if (settings_reset === 1'b1) n_rst++;
        if (open_all_channels === 1'b1) n_open++;
        if (selftest_start === 1'b1) n_st++;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (exp !== got) begin
            fails++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic idle(input int n);
        cmd_valid <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    // Leaves valid high so that a following send goes back to back.
    task automatic send(input cch_cmd_type c);
        int i;
        cmd_valid <= 1'b1;
        cmd_code  <= c;
        for (i = 0; i < 500; i++) begin
            @(posedge clk);
            if (cmd_ready === 1'b1) break;
        end
        if (i == 500) begin
            fails++;
            final_report();
        end
    endtask

    task automatic mark();
        prev_n = n_replies;
        prev_c = rx_count;
    endtask

    task automatic collect(input string s);
        int i;
        logic [63:0] v, m;
        v = 64'h0;
        foreach (s[k]) v = {v[55:0], s[k]};
        m = (s.len() >= 8) ? '1 : (64'h1 << (8 * s.len())) - 64'h1;
        for (i = 0; i < 500 && n_replies == prev_n; i++) @(posedge clk);
        if (i == 500) begin
            fails++;
            final_report();
        end
        check(s.len(), rx_count - prev_c);
        check(v, rx_tail & m);
    endtask

    task automatic query(input cch_cmd_type c, input string s);
        mark();
        send(c);
        idle(1);
        collect(s);
    endtask

    task automatic esr();
        query(CMD_ESRQ, $sformatf("%0d", e_sesr));
        e_sesr = 8'h00;
    endtask

    initial begin
        seed = 84294;
        reset = 1'b1;
        {scan_finished, slow, fail_mode} = 3'h0;
        cmd_valid = 1'b0;
        op_busy = 1'b0;
        scan_list_enabled = 1'b0;
        cmd_code = CMD_IDN;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        idle(2);
        e_sesr = 8'h80;
        check(e_sesr, sesr);
        $display("test reset done");
        slow <= 1'b1;
        query(CMD_IDN, "VENDOR,SWMAIN,000000001,V1.00");
        slow <= 1'b0;
        $display("test identification done");
        for (int k = 0; k < 2; k++) begin
            fail_mode <= k[0];
            query(CMD_TST, k ? "FAIL" : "PASS");
            check(k + 1, n_st);
        end
        $display("test self-test done");
        send(CMD_TRG);
        idle(3);
        check(0, n_start);
        scan_list_enabled <= 1'b1;
        send(CMD_TRG);
        idle(3);
        check(1, n_start);
        check(1, scan_active);
        send(CMD_TRG);
        send(CMD_TRG);
        idle(3);
        check(2, n_adv);
        mark();
        send(CMD_TST);
        idle(10);
        check(prev_n, n_replies);
        check(2, n_st);
        e_sesr = e_sesr | 8'h10;
        esr();
        send(CMD_UNKNOWN);
        idle(3);
        e_sesr = 8'h20;
        esr();
        $display("test scan done");
        nb = 3 + ({$random(seed)} % 8);
        op_busy <= 1'b1;
        send(CMD_OPC);
        idle(nb);
        check(0, cmd_ready);
        check(0, sesr[0]);
        op_busy <= 1'b0;
        send(CMD_UNKNOWN);
        idle(2);
        check(1, sesr[0]);
        e_sesr = 8'h21;
        esr();
        nb = 3 + ({$random(seed)} % 8);
        op_busy <= 1'b1;
        mark();
        send(CMD_OPCQ);
        idle(nb);
        check(prev_n, n_replies);
        op_busy <= 1'b0;
        collect("1");
        $display("test operation complete done");
        op_busy <= 1'b1;
        send(CMD_WAI);
        send(CMD_TRG);
        send(CMD_UNKNOWN);
        idle(3);
        check(3, n_adv);
        check(0, cmd_ready);
        check(8'h00, sesr);
        op_busy <= 1'b0;
        idle(4);
        check(8'h20, sesr);
        e_sesr = 8'h20;
        esr();
        $display("test wait done");
        scan_finished <= 1'b1;
        @(posedge clk);
        scan_finished <= 1'b0;
        idle(2);
        check(0, scan_active);
        send(CMD_TRG);
        idle(2);
        check(1, scan_active);
        send(CMD_RST);
        idle(3);
        check(1, n_rst);
        check(1, n_open);
        check(0, scan_active);
        check(e_sesr, sesr);
        $display("test device reset done");
        final_report();
    end
endmodule
